// *** msc_config_regs.sv ***
`timescale 1ns/10ps
module msc_config_regs import msc_pkg::*; #(
    parameter int INT0_LONG_CYCLES = INT0_ON_LONG_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    // accelerometer trim
    output logic [3:0] user_gain_a_high,
    output logic [3:0] infl_offset_code [3],
    output logic [3:0] infl_gain_code [3],
    output logic signed [7:0] infl_offset_temp_c [3],
    output logic signed [7:0] infl_gain_temp_c [3],
    // accelerometer filters
    output logic rate_converter_on,
    output logic prefilter_on,
    output logic [2:0] stabilize_highpass_cutoff,
    output logic stabilize_highpass_active,
    output logic [6:0] low_power_average_count,
    output logic stabilize_filter_order,
    output logic [2:0] stabilize_lowpass_cutoff,
    output logic stabilize_lowpass_active,
    output logic comb_filter_active,
    output logic main_lowpass_active,
    output logic main_antialias_order,
    output logic [2:0] main_lowpass_div_log2,
    // temperature path
    output logic [2:0] temperature_decimation,
    output logic [2:0] temperature_lowpass_select,
    output logic temperature_test_inject,
    // embedded processor
    output logic [15:0] vector_start_address [3],
    output logic [7:0] stack_start_address,
    // timestamp
    output logic timestamp_enable,
    output logic timestamp_frame_sync_enable,
    output logic auxiliary_fine_count_force,
    // sample formatting
    input wire logic sample_valid,
    input wire logic [19:0] sample_data,
    output logic fmt_valid,
    output logic [7:0] fmt_byte_first,
    output logic [7:0] fmt_byte_second,
    output logic [3:0] fmt_ext,
    // interrupt 0
    input wire logic int0_pulse_mode,
    input wire logic int0_event,
    input wire logic int0_level,
    output logic int0_out
);

    // =====================================================================
    // register file
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] regs_d [NUM_REGS];
    logic [7:0] rdata_q, rdata_d;
    logic rd_valid_q, rd_valid_d;

    // returns {hit, index}; unmapped addresses miss
    function automatic logic [5:0] lookup(input logic [7:0] addr);
        logic [5:0] res;
        res = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (REG_OFFSET[i] == addr) begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction

    logic [5:0] wr_hit, rd_hit;

    always_comb begin
        wr_hit = lookup(reg_addr);
        rd_hit = lookup(reg_addr);
        regs_d = regs_q;
        // reserved bits never store, so they read as zero
        if (reg_wr_en && wr_hit[5]) begin
            regs_d[wr_hit[4:0]] = reg_wdata & REG_MASK[wr_hit[4:0]];
        end
        rd_valid_d = reg_rd_en;
        rdata_d = rdata_q;
        if (reg_rd_en) begin
            rdata_d = rd_hit[5] ? regs_q[rd_hit[4:0]] : 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= REG_RESET[i] & REG_MASK[i];
            end
            rdata_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            regs_q <= regs_d;
            rdata_q <= rdata_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;

    // =====================================================================
    // raw fields straight from the register flops
    assign user_gain_a_high = regs_q[IDX_GAIN_HIGH][3:0];
    assign stabilize_highpass_cutoff = regs_q[IDX_HP_AVG][HP_CUT_LSB +: 3];
    assign stabilize_filter_order = regs_q[IDX_STAB_LP][STAB_ORDER_BIT];
    assign stabilize_lowpass_cutoff = regs_q[IDX_STAB_LP][2:0];
    assign main_antialias_order = regs_q[IDX_BYP_MAIN][MAIN_ORDER_BIT];
    assign temperature_decimation = regs_q[IDX_TEMP][TEMP_DEC_LSB +: 3];
    assign temperature_lowpass_select = regs_q[IDX_TEMP][TEMP_LP_LSB +: 3];
    assign temperature_test_inject = regs_q[IDX_TEMP][TEMP_INJ_BIT];
    assign stack_start_address = regs_q[IDX_STACK];
    assign timestamp_enable = regs_q[IDX_TIMESTAMP][TS_EN_BIT];
    assign timestamp_frame_sync_enable = regs_q[IDX_TIMESTAMP][TS_FRAME_SYNC_INPUT_BIT];
    assign auxiliary_fine_count_force = regs_q[IDX_TIMESTAMP][TS_AUX_BIT];

    always_comb begin
        for (int v = 0; v < 3; v++) begin
            vector_start_address[v] = {regs_q[IDX_VEC0_LOW + 2 * v + 1],
                                       regs_q[IDX_VEC0_LOW + 2 * v]};
        end
        for (int a = 0; a < 3; a++) begin
            infl_offset_code[a] = regs_q[IDX_INFL_X + a][INFL_OFF_LSB +: 4];
            infl_gain_code[a] = regs_q[IDX_INFL_X + a][3:0];
        end
    end

    // =====================================================================
    // decoded settings, registered one cycle behind the fields
    logic signed [7:0] off_temp_q [3], off_temp_d [3];
    logic signed [7:0] gain_temp_q [3], gain_temp_d [3];
    logic conv_on_q, conv_on_d, pre_on_q, pre_on_d;
    logic hp_act_q, hp_act_d, lp_act_q, lp_act_d;
    logic comb_act_q, comb_act_d, main_act_q, main_act_d;
    logic [6:0] avg_q, avg_d;
    logic [2:0] main_div_q, main_div_d;

    always_comb begin
        for (int a = 0; a < 3; a++) begin
            off_temp_d[a] = msc_infl_temp(regs_q[IDX_INFL_X + a][INFL_OFF_LSB +: 4]);
            gain_temp_d[a] = msc_infl_temp(regs_q[IDX_INFL_X + a][3:0]);
        end
        // reserved converter code leaves both stages off
        conv_on_d = regs_q[IDX_RATE_CONV][1:0] == CONV_BOTH;
        pre_on_d = (regs_q[IDX_RATE_CONV][1:0] == CONV_BOTH)
                || (regs_q[IDX_RATE_CONV][1:0] == CONV_PREFILTER);
        hp_act_d = !regs_q[IDX_BYP_MAIN][STAB_HP_BYP_BIT]
                && (regs_q[IDX_HP_AVG][HP_CUT_LSB +: 3] != 3'h0);
        avg_d = msc_avg_count(regs_q[IDX_HP_AVG][3:0]);
        lp_act_d = regs_q[IDX_STAB_LP][2:0] != 3'h0;
        comb_act_d = !regs_q[IDX_BYP_MAIN][COMB_BYP_BIT];
        main_act_d = !regs_q[IDX_BYP_MAIN][MAIN_LP_BYP_BIT]
                && (regs_q[IDX_BYP_MAIN][2:0] != 3'h0);
        // divide exponent: code 0 is output rate over 2
        main_div_d = msc_clip_cut(regs_q[IDX_BYP_MAIN][2:0]) + 3'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            for (int a = 0; a < 3; a++) begin
                off_temp_q[a] <= 8'sh14;
                gain_temp_q[a] <= 8'sh14;
            end
            conv_on_q <= 1'b0;
            pre_on_q <= 1'b0;
            hp_act_q <= 1'b0;
            avg_q <= 7'h04;
            lp_act_q <= 1'b1;
            comb_act_q <= 1'b1;
            main_act_q <= 1'b0;
            main_div_q <= 3'h1;
        end else begin
            off_temp_q <= off_temp_d;
            gain_temp_q <= gain_temp_d;
            conv_on_q <= conv_on_d;
            pre_on_q <= pre_on_d;
            hp_act_q <= hp_act_d;
            avg_q <= avg_d;
            lp_act_q <= lp_act_d;
            comb_act_q <= comb_act_d;
            main_act_q <= main_act_d;
            main_div_q <= main_div_d;
        end
    end

    assign infl_offset_temp_c = off_temp_q;
    assign infl_gain_temp_c = gain_temp_q;
    assign rate_converter_on = conv_on_q;
    assign prefilter_on = pre_on_q;
    assign stabilize_highpass_active = hp_act_q;
    assign low_power_average_count = avg_q;
    assign stabilize_lowpass_active = lp_act_q;
    assign comb_filter_active = comb_act_q;
    assign main_lowpass_active = main_act_q;
    assign main_lowpass_div_log2 = main_div_q;

    // =====================================================================
    // sample formatter: width and byte order
    logic fmt_valid_q, fmt_valid_d;
    logic [7:0] b_first_q, b_first_d, b_second_q, b_second_d;
    logic [3:0] ext_q, ext_d;

    always_comb begin
        fmt_valid_d = sample_valid;
        b_first_d = b_first_q;
        b_second_d = b_second_q;
        ext_d = ext_q;
        if (sample_valid) begin
            // main bytes always carry bits 19:4
            if (regs_q[IDX_FORMAT][ORDER_BIT]) begin
                b_first_d = sample_data[19:12];
                b_second_d = sample_data[11:4];
            end else begin
                b_first_d = sample_data[11:4];
                b_second_d = sample_data[19:12];
            end
            ext_d = regs_q[IDX_FORMAT][WIDE_BIT] ? sample_data[3:0] : 4'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            fmt_valid_q <= 1'b0;
            b_first_q <= 8'h00;
            b_second_q <= 8'h00;
            ext_q <= 4'h0;
        end else begin
            fmt_valid_q <= fmt_valid_d;
            b_first_q <= b_first_d;
            b_second_q <= b_second_d;
            ext_q <= ext_d;
        end
    end

    assign fmt_valid = fmt_valid_q;
    assign fmt_byte_first = b_first_q;
    assign fmt_byte_second = b_second_q;
    assign fmt_ext = ext_q;

    // =====================================================================
    // interrupt 0 minimum on-time stretcher
    msc_int0_state_t st_q, st_d;
    logic [ON_CNT_W-1:0] on_cnt_q, on_cnt_d;
    logic int0_q, int0_d;
    logic [ON_CNT_W-1:0] on_load;

    always_comb begin
        // reserved codes fall back to the longer, safer time
        if (regs_q[IDX_INT0_ON][2:0] == INT0_ON_SHORT_CODE) begin
            on_load = ON_CNT_W'(INT0_ON_SHORT_CYCLES - 1);
        end else begin
            on_load = ON_CNT_W'(INT0_LONG_CYCLES - 1);
        end
        st_d = st_q;
        on_cnt_d = on_cnt_q;
        int0_d = int0_q;
        if (!int0_pulse_mode) begin
            st_d = INT0_IDLE;
            on_cnt_d = '0;
            int0_d = int0_level;
        end else begin
            unique case (st_q)
                INT0_IDLE: begin
                    int0_d = 1'b0;
                    if (int0_event) begin
                        st_d = INT0_HOLD;
                        on_cnt_d = on_load;
                        int0_d = 1'b1;
                    end
                end
                INT0_HOLD: begin
                    int0_d = 1'b1;
                    // a new event restarts the full on-time
                    if (int0_event) begin
                        on_cnt_d = on_load;
                    end else if (on_cnt_q == '0) begin
                        st_d = INT0_IDLE;
                        int0_d = 1'b0;
                    end else begin
                        on_cnt_d = on_cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= INT0_IDLE;
            on_cnt_q <= '0;
            int0_q <= 1'b0;
        end else begin
            st_q <= st_d;
            on_cnt_q <= on_cnt_d;
            int0_q <= int0_d;
        end
    end

    assign int0_out = int0_q;

endmodule

// *** msc_config_regs_asserts.sv ***
`timescale 1ns/10ps
module msc_config_regs_asserts import msc_pkg::*; #(
    parameter int INT0_LONG_CYCLES = INT0_ON_LONG_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    input wire logic reg_rd_valid,
    // fields
    input wire logic [3:0] user_gain_a_high,
    input wire logic rate_converter_on,
    input wire logic prefilter_on,
    input wire logic [6:0] low_power_average_count,
    input wire logic [15:0] vector_start_address [3],
    input wire logic [7:0] stack_start_address,
    // formatter and interrupt
    input wire logic sample_valid,
    input wire logic fmt_valid,
    input wire logic int0_pulse_mode,
    input wire logic int0_event,
    input wire logic int0_level,
    input wire logic int0_out
);
    // =========================================================
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    read_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe not answered");
    read_single_a: assert property (!reg_rd_en |=> !reg_rd_valid)
        else $error("read valid without strobe");
    gain_write_a: assert property (reg_wr_en && reg_addr == 8'h17 |=>
        user_gain_a_high == $past(reg_wdata[3:0])) else $error("gain nibble not stored");
    vector_low_a: assert property (reg_wr_en && reg_addr == 8'h4f |=>
        vector_start_address[0][7:0] == $past(reg_wdata)) else $error("vector low byte lost");
    stack_write_a: assert property (reg_wr_en && reg_addr == 8'h55 |=>
        stack_start_address == $past(reg_wdata)) else $error("stack address not stored");
    avg_sat_a: assert property (reg_wr_en && reg_addr == 8'h6e && reg_wdata[3:0] >= 4'hc
        |=> ##1 low_power_average_count == 7'h40) else $error("averaging not saturated");
    conv_both_a: assert property (reg_wr_en && reg_addr == 8'h6d && reg_wdata[1:0] == 2'h2
        |=> ##1 (rate_converter_on && prefilter_on)) else $error("converter not both on");
    fmt_pulse_a: assert property (sample_valid |=> fmt_valid)
        else $error("sample not formatted");
    fmt_cause_a: assert property (fmt_valid |-> $past(sample_valid))
        else $error("format valid without sample");
    int0_hold_a: assert property (int0_pulse_mode && int0_event |=> int0_out [*8])
        else $error("interrupt pulse too short");
    int0_cause_a: assert property ($rose(int0_out) |-> $past(int0_event) ||
        ($past(int0_level) && !$past(int0_pulse_mode))) else $error("interrupt without cause");
    int0_level_a: assert property (!int0_pulse_mode && !$past(int0_pulse_mode) && $past(rstn)
        |-> int0_out == $past(int0_level)) else $error("level interrupt not followed");
endmodule

bind msc_config_regs msc_config_regs_asserts #(.INT0_LONG_CYCLES(INT0_LONG_CYCLES)) chk_u (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rd_valid(reg_rd_valid),
    .user_gain_a_high(user_gain_a_high), .rate_converter_on(rate_converter_on),
    .prefilter_on(prefilter_on), .low_power_average_count(low_power_average_count),
    .vector_start_address(vector_start_address), .stack_start_address(stack_start_address),
    .sample_valid(sample_valid), .fmt_valid(fmt_valid), .int0_pulse_mode(int0_pulse_mode),
    .int0_event(int0_event), .int0_level(int0_level), .int0_out(int0_out));

// *** msc_config_regs_tb.sv ***
`timescale 1ns/10ps
module msc_config_regs_tb import msc_pkg::*;;
    // short long-pulse count keeps the run brief; 8 us is 1600 cycles
    localparam int LONG = 40;
    localparam int SHORT = 1600;
    localparam logic [6:0] AVG [16] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h07, 7'h08, 7'h0a,
        7'h0b, 7'h10, 7'h12, 7'h14, 7'h20, 7'h40, 7'h40, 7'h40, 7'h40};
    logic sys_clk, rstn, reg_wr_en, reg_rd_en, reg_rd_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, stack_start_address;
    logic [3:0] user_gain_a_high, fmt_ext;
    logic [3:0] infl_offset_code [3];
    logic [3:0] infl_gain_code [3];
    logic signed [7:0] infl_offset_temp_c [3];
    logic signed [7:0] infl_gain_temp_c [3];
    logic rate_converter_on, prefilter_on, stabilize_highpass_active, stabilize_filter_order;
    logic stabilize_lowpass_active, comb_filter_active, main_lowpass_active;
    logic main_antialias_order, temperature_test_inject, timestamp_enable;
    logic timestamp_frame_sync_enable, auxiliary_fine_count_force;
    logic [2:0] stabilize_highpass_cutoff, stabilize_lowpass_cutoff, main_lowpass_div_log2;
    logic [2:0] temperature_decimation, temperature_lowpass_select;
    logic [6:0] low_power_average_count;
    logic [15:0] vector_start_address [3];
    logic sample_valid, fmt_valid, int0_pulse_mode, int0_event, int0_level, int0_out;
    logic [19:0] sample_data;
    logic [7:0] fmt_byte_first, fmt_byte_second;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    msc_config_regs #(.INT0_LONG_CYCLES(LONG)) dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .user_gain_a_high(user_gain_a_high),
        .infl_offset_code(infl_offset_code), .infl_gain_code(infl_gain_code),
        .infl_offset_temp_c(infl_offset_temp_c), .infl_gain_temp_c(infl_gain_temp_c),
        .rate_converter_on(rate_converter_on), .prefilter_on(prefilter_on),
        .stabilize_highpass_cutoff(stabilize_highpass_cutoff),
        .stabilize_highpass_active(stabilize_highpass_active),
        .low_power_average_count(low_power_average_count),
        .stabilize_filter_order(stabilize_filter_order),
        .stabilize_lowpass_cutoff(stabilize_lowpass_cutoff),
        .stabilize_lowpass_active(stabilize_lowpass_active),
        .comb_filter_active(comb_filter_active), .main_lowpass_active(main_lowpass_active),
        .main_antialias_order(main_antialias_order),
        .main_lowpass_div_log2(main_lowpass_div_log2),
        .temperature_decimation(temperature_decimation),
        .temperature_lowpass_select(temperature_lowpass_select),
        .temperature_test_inject(temperature_test_inject),
        .vector_start_address(vector_start_address), .stack_start_address(stack_start_address),
        .timestamp_enable(timestamp_enable),
        .timestamp_frame_sync_enable(timestamp_frame_sync_enable),
        .auxiliary_fine_count_force(auxiliary_fine_count_force), .sample_valid(sample_valid),
        .sample_data(sample_data), .fmt_valid(fmt_valid), .fmt_byte_first(fmt_byte_first),
        .fmt_byte_second(fmt_byte_second), .fmt_ext(fmt_ext), .int0_pulse_mode(int0_pulse_mode),
        .int0_event(int0_event), .int0_level(int0_level), .int0_out(int0_out));

    // =========================================================
    // clock, timeout and helpers
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // write strobe stays up so writes can run back to back; rel drops it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
    endtask

    task automatic rel();
        reg_wr_en = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd_en = 1'b1;
        reg_addr = a;
        tick(1);
        reg_rd_en = 1'b0;
        check(20'(reg_rd_valid), 20'h1);
        check(20'(reg_rdata), 20'(exp));
        tick(1);
    endtask

    function automatic logic signed [7:0] tmid(input int k);
        return (k >= 11) ? 8'sd60 : 8'(8 * k - 28);
    endfunction

    task automatic chk_fmt(input logic [19:0] d, input logic [1:0] k);
        check(20'(fmt_valid), 20'h1);
        check(20'(fmt_byte_first), 20'(k[0] ? d[19:12] : d[11:4]));
        check(20'(fmt_byte_second), 20'(k[0] ? d[11:4] : d[19:12]));
        check(20'(fmt_ext), 20'(k[1] ? d[3:0] : 4'h0));
    endtask

    task automatic pulse(input logic [2:0] code, input int again, input int n);
        int cnt;
        cnt = 0;
        wr(8'h62, {5'h00, code});
        rel();
        check(20'(int0_out), 20'h0);
        int0_pulse_mode = 1'b1;
        int0_event = 1'b1;
        tick(1);
        while (int0_out === 1'b1 && cnt < 2000) begin
            cnt++;
            int0_event = (cnt == again);
            tick(1);
        end
        int0_event = 1'b0;
        check(20'(cnt), 20'(n));
    endtask

    // =========================================================
    // main sequence
    initial begin
        logic [7:0] v;
        {rstn, reg_wr_en, reg_rd_en, reg_addr, reg_wdata, sample_valid, sample_data} = '0;
        {int0_pulse_mode, int0_event, int0_level} = '0;
        tick(5);
        rstn = 1'b1;
        for (int i = 0; i < NUM_REGS; i++) begin
            rd(REG_OFFSET[i], REG_RESET[i] & REG_MASK[i]);
            wr(REG_OFFSET[i], 8'hff);
            rel();
            rd(REG_OFFSET[i], REG_MASK[i]);
        end
        wr(8'h00, 8'hff);
        rel();
        rd(8'h00, 8'h00);
        wr(8'h17, 8'ha5);
        check(20'(user_gain_a_high), 20'h5);
        for (int i = 0; i < 3; i++) begin
            wr(8'(8'h4f + 2 * i), 8'(16 * i + 1));
            wr(8'(8'h50 + 2 * i), 8'(16 * i + 9));
        end
        wr(8'h55, 8'hc3);
        rel();
        for (int i = 0; i < 3; i++) begin
            check(20'(vector_start_address[i]), 20'({8'(16 * i + 9), 8'(16 * i + 1)}));
        end
        check(20'(stack_start_address), 20'hc3);
        for (int c = 0; c < 16; c++) begin
            v = 8'(c * 37) & 8'h7f;
            wr(8'h6e, {1'b0, 3'(c % 5), 4'(c)});
            wr(8'h6d, v);
            wr(8'h6f, v);
            wr(8'h70, v);
            wr(8'h75, v);
            wr(8'h58, v);
            rel();
            check(20'(rate_converter_on), 20'(v[1:0] == 2'h2));
            check(20'(prefilter_on), 20'(v[1:0] == 2'h1 || v[1:0] == 2'h2));
            check(20'(stabilize_highpass_cutoff), 20'(c % 5));
            check(20'(stabilize_highpass_active), 20'(c % 5 != 0 && !v[5]));
            check(20'(low_power_average_count), 20'(AVG[c]));
            check(20'(stabilize_filter_order), 20'(v[3]));
            check(20'(stabilize_lowpass_cutoff), 20'(v[2:0]));
            check(20'(stabilize_lowpass_active), 20'(v[2:0] != 3'h0));
            check(20'(comb_filter_active), 20'(!v[6]));
            check(20'(main_lowpass_active), 20'(!v[4] && v[2:0] != 3'h0));
            check(20'(main_antialias_order), 20'(v[3]));
            check(20'(main_lowpass_div_log2), 20'(v[2:0] >= 3'h6 ? 3'h7 : v[2:0] + 3'h1));
            check(20'(temperature_decimation), 20'(v[6:4]));
            check(20'(temperature_lowpass_select), 20'(v[3:1]));
            check(20'(temperature_test_inject), 20'(v[0]));
            check(20'({auxiliary_fine_count_force, timestamp_frame_sync_enable,
                timestamp_enable}), 20'(v[2:0]));
        end
        for (int n = 0; n < 16; n++) begin
            wr(8'(8'h69 + n % 3), {4'(n), 4'(15 - n)});
            rel();
            check(20'(infl_offset_code[n % 3]), 20'(n));
            check(20'(infl_gain_code[n % 3]), 20'(15 - n));
            check(20'(infl_offset_temp_c[n % 3]), 20'(tmid(n)));
            check(20'(infl_gain_temp_c[n % 3]), 20'(tmid(15 - n)));
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h60, {4'h0, 1'(k / 2), 1'b0, 1'(k % 2), 1'b0});
            rel();
            sample_valid = 1'b1;
            sample_data = 20'habcde;
            tick(1);
            sample_data = 20'h13579;
            chk_fmt(20'habcde, 2'(k));
            tick(1);
            sample_valid = 1'b0;
            chk_fmt(20'h13579, 2'(k));
            tick(1);
        end
        pulse(3'h0, 0, LONG);
        pulse(3'h1, 0, SHORT);
        pulse(3'h0, 7, LONG + 7);
        pulse(3'h5, 0, LONG);
        int0_pulse_mode = 1'b0;
        int0_level = 1'b1;
        tick(2);
        check(20'(int0_out), 20'h1);
        int0_level = 1'b0;
        tick(1);
        check(20'(int0_out), 20'h0);
        wr(8'h55, 8'h5a);
        rel();
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        rd(8'h55, 8'h00);
        results();
    end
endmodule

// *** msc_pkg.sv ***
package msc_pkg;

    // =====================================================================
    // register map
    localparam int NUM_REGS = 19;
    typedef logic [7:0] msc_byte_t;

    localparam int IDX_GAIN_HIGH = 0;
    localparam int IDX_VEC0_LOW = 1;
    localparam int IDX_STACK = 7;
    localparam int IDX_TIMESTAMP = 8;
    localparam int IDX_FORMAT = 9;
    localparam int IDX_INT0_ON = 10;
    localparam int IDX_INFL_X = 11;
    localparam int IDX_RATE_CONV = 14;
    localparam int IDX_HP_AVG = 15;
    localparam int IDX_STAB_LP = 16;
    localparam int IDX_BYP_MAIN = 17;
    localparam int IDX_TEMP = 18;

    localparam msc_byte_t REG_OFFSET [NUM_REGS] = '{
        8'h17, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h58, 8'h60,
        8'h62, 8'h69, 8'h6a, 8'h6b, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h75};
    localparam msc_byte_t REG_RESET [NUM_REGS] = '{
        8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h0a,
        8'h01, 8'h66, 8'h66, 8'h66, 8'h00, 8'h02, 8'h01, 8'h20, 8'h00};
    // writable bits; everything else is reserved and reads zero
    localparam msc_byte_t REG_MASK [NUM_REGS] = '{
        8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'h0a,
        8'h07, 8'hff, 8'hff, 8'hff, 8'h03, 8'h7f, 8'h0f, 8'h7f, 8'h7f};

    // =====================================================================
    // field positions
    localparam int INFL_OFF_LSB = 4;
    localparam int HP_CUT_LSB = 4;
    localparam int STAB_ORDER_BIT = 3;
    localparam int COMB_BYP_BIT = 6;
    localparam int STAB_HP_BYP_BIT = 5;
    localparam int MAIN_LP_BYP_BIT = 4;
    localparam int MAIN_ORDER_BIT = 3;
    localparam int TEMP_DEC_LSB = 4;
    localparam int TEMP_LP_LSB = 1;
    localparam int TEMP_INJ_BIT = 0;
    localparam int TS_EN_BIT = 0;
    localparam int TS_FRAME_SYNC_INPUT_BIT = 1;
    localparam int TS_AUX_BIT = 2;
    localparam int WIDE_BIT = 3;
    localparam int ORDER_BIT = 1;

    // =====================================================================
    // field codes
    localparam logic [1:0] CONV_PREFILTER = 2'h1;
    localparam logic [1:0] CONV_BOTH = 2'h2;
    localparam logic [2:0] INT0_ON_SHORT_CODE = 3'h1;
    localparam logic [3:0] INFL_SAT_CODE = 4'hb;
    localparam logic signed [7:0] INFL_BASE_C = -8'sd28;
    localparam logic signed [7:0] INFL_SAT_C = 8'sd60;
    localparam logic [2:0] CUT_CODE_MAX = 3'h6;

    // =====================================================================
    // timing at sys_clk
    localparam int CLK_PERIOD_NS = 5;
    localparam int INT0_ON_LONG_NS = 100000;
    localparam int INT0_ON_SHORT_NS = 8000;
    localparam int INT0_ON_LONG_CYCLES = (INT0_ON_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INT0_ON_SHORT_CYCLES =
        (INT0_ON_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ON_CNT_W = 15;

    typedef enum logic {INT0_IDLE, INT0_HOLD} msc_int0_state_t;

    // =====================================================================
    // decoders
    function automatic logic signed [7:0] msc_infl_temp(input logic [3:0] code);
        if (code >= INFL_SAT_CODE) begin
            return INFL_SAT_C;
        end
        return INFL_BASE_C + $signed({1'b0, code, 3'h0});
    endfunction

    function automatic logic [6:0] msc_avg_count(input logic [3:0] code);
        case (code)
            4'h0: return 7'h01;
            4'h1: return 7'h02;
            4'h2: return 7'h04;
            4'h3: return 7'h05;
            4'h4: return 7'h07;
            4'h5: return 7'h08;
            4'h6: return 7'h0a;
            4'h7: return 7'h0b;
            4'h8: return 7'h10;
            4'h9: return 7'h12;
            4'ha: return 7'h14;
            4'hb: return 7'h20;
            default: return 7'h40;
        endcase
    endfunction

    // codes 6 and 7 share the deepest setting
    function automatic logic [2:0] msc_clip_cut(input logic [2:0] code);
        return (code > CUT_CODE_MAX) ? CUT_CODE_MAX : code;
    endfunction

endpackage
